//--- src/clwp_card_lock.sv
// Purpose: group write protection and password lock of a memory card
// Assumes: link bytes framed by host clock, crc already checked upstream
// Notes:   password store is held by its own non-volatile reset only
// Functional notes
// RULE1: groups protectable only when group protection allowed
// RULE2: protect sets, unprotect clears addressed group
// RULE3: query returns 32 group bits plus crc16
// RULE4: group address rounded down to group boundary
// RULE5: 128-bit password, 8-bit length, non-volatile
// RULE6: locked card refuses data class commands
// RULE7: reset locks card when length nonzero
// RULE8: lock command only while card selected
// RULE9: lock command data arrives as one block
// RULE10: byte0 mode, byte1 length, then password
// RULE11: forced erase uses erase bit alone
// RULE12: lock bit locks, clear ignores it
// RULE13: password length valid from 1 to 16
// RULE14: host sets block length, adds crc
// RULE15: replacement sends old then new password
// RULE16: set needs old match, else fail flag
// RULE17: length zero means no password
// RULE18: matching clear empties store, else fail
// RULE19: matching lock locks card, else fail
// RULE20: lock on locked or empty card fails
// RULE21: unlock lasts for this power session
// RULE22: unlock on unlocked card fails
// RULE23: forced erase wipes password, groups, temp protect
// RULE24: erase on unlocked card or extra bits fails
// RULE25: mode bits set, clear, lock, erase; rest zero
`timescale 1ns/1ps
`include "clwp_cfg.svh"
module clwp_card_lock
   import clwp_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        nvm_blank_n,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        lnk_clk,
   input  wire logic        lnk_frame,
   input  wire logic [7:0]  lnk_data,
   output logic             card_locked,
   output logic             lock_failure_flag
);
   // ==========
   // link sampling
   logic [2:0] lclk_s_q;
   logic [2:0] lfrm_s_q;
   logic [7:0] ldat1_q;
   logic [7:0] ldat2_q;
   logic       lrise;
   logic       lfall_frm;

   // two-stage sync; stage 0 feeds only stage 1
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lclk_s_q <= 3'h0;
         lfrm_s_q <= 3'h0;
         ldat1_q  <= 8'h00;
         ldat2_q  <= 8'h00;
      end else if (ce) begin
         lclk_s_q <= {lclk_s_q[1:0], lnk_clk};
         lfrm_s_q <= {lfrm_s_q[1:0], lnk_frame};
         ldat1_q  <= lnk_data;
         ldat2_q  <= ldat1_q;
      end
   end

   // data and frame share the clock's sync depth, so they align at the edge
   assign lrise     = lclk_s_q[1] & ~lclk_s_q[2];
   assign lfall_frm = lfrm_s_q[2] & ~lfrm_s_q[1];

   // ==========
   // register bus
   logic        ctrl_gen_q;
   logic        ctrl_sel_q;
   logic        ctrl_twp_q;
   logic [3:0]  ctrl_sz_q;
   logic [31:0] arg_q;
   logic [31:0] qbits_q;
   logic [15:0] qcrc_q;
   logic        illegal_q;
   logic        fail_q;
   logic        locked_q;
   logic        boot_q;
   logic        wr_en;
   logic        cmd_wr;
   logic        stat_wr;
   logic        mapped;
   logic [31:0] rd_val;
   clwp_op_type op;
   clwp_lk_type lk_q;

   // write lands on the edge that sees pready high
   assign wr_en   = psel & penable & pready & pwrite;
   assign cmd_wr  = wr_en & (paddr == `CLWP_OFF_CMD);
   assign stat_wr = wr_en & (paddr == `CLWP_OFF_STAT);
   assign op      = clwp_op_type'(pwdata[2:0]);

   // read mux and decode
   always_comb begin
      mapped = 1'b1;
      rd_val = 32'h0000_0000;
      case (paddr)
         `CLWP_OFF_CTRL: begin
            rd_val[`CLWP_CTRL_GEN] = ctrl_gen_q;
            rd_val[`CLWP_CTRL_SEL] = ctrl_sel_q;
            rd_val[`CLWP_CTRL_TWP] = ctrl_twp_q;
            rd_val[`CLWP_CTRL_SZ_HI:`CLWP_CTRL_SZ_LO] = ctrl_sz_q;
         end
         `CLWP_OFF_CMD:   rd_val = 32'h0000_0000;
         `CLWP_OFF_ARG:   rd_val = arg_q;
         `CLWP_OFF_STAT: begin
            rd_val[`CLWP_ST_LOCKED]  = locked_q;
            rd_val[`CLWP_ST_FAIL]    = fail_q;
            rd_val[`CLWP_ST_ILLEGAL] = illegal_q;
            rd_val[`CLWP_ST_BUSY]    = (lk_q != CLWP_LK_IDLE);
         end
         `CLWP_OFF_QBITS: rd_val = qbits_q;
         `CLWP_OFF_QCRC:  rd_val = {16'h0000, qcrc_q};
         `CLWP_OFF_PLEN:  rd_val = 32'h0000_0000;
         default:         mapped = 1'b0;
      endcase
   end

   // one wait state; data and error come with pready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (ce) begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped;
         if (psel & penable & ~pready & ~pwrite) begin
            prdata <= rd_val;
         end
      end
   end

   // ==========
   // control and argument registers
   logic do_erase;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_gen_q <= 1'b0;
         ctrl_sel_q <= 1'b0;
         ctrl_twp_q <= 1'b0;
         ctrl_sz_q  <= 4'h0;
      end else if (ce) begin
         if (wr_en && paddr == `CLWP_OFF_CTRL) begin
            ctrl_gen_q <= pwdata[`CLWP_CTRL_GEN];
            ctrl_sel_q <= pwdata[`CLWP_CTRL_SEL];
            ctrl_twp_q <= pwdata[`CLWP_CTRL_TWP];
            ctrl_sz_q  <= pwdata[`CLWP_CTRL_SZ_HI:`CLWP_CTRL_SZ_LO];
         end
         if (do_erase) begin
            ctrl_twp_q <= 1'b0; // RULE23
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arg_q <= 32'h0000_0000;
      end else if (ce && wr_en && paddr == `CLWP_OFF_ARG) begin
         arg_q <= pwdata;
      end
   end

   // ==========
   // protection groups
   logic [`CLWP_NGRP-1:0]  grp_q;
   logic [31:0]            gsh;
   logic [5:0]             gidx;
   logic [`CLWP_QBITS-1:0] qsel;
   logic                   grp_ok;
   logic                   lk_ok;

   // shifting by block and group size drops the low address bits
   assign gsh  = arg_q >> (`CLWP_BLK_SHIFT + 5'(ctrl_sz_q)); // RULE4
   assign gidx = gsh[5:0];

   // data class commands need an unlocked card with groups allowed
   assign grp_ok = ~locked_q & ctrl_gen_q; // RULE1 RULE6
   assign lk_ok  = ctrl_sel_q & (lk_q == CLWP_LK_IDLE); // RULE8

   // 32 groups from the addressed one, wrapping at the top
   always_comb begin
      qsel = '0;
      for (int i = 0; i < `CLWP_QBITS; i++) begin
         qsel[i] = grp_q[gidx + 6'(i)]; // RULE3
      end
   end

   // crc16 over the query bits, first group first
   function automatic logic [15:0] clwp_crc16(input logic [`CLWP_QBITS-1:0] d);
      logic [15:0] c;
      logic        fb;
      c = `CLWP_CRC_INIT;
      for (int i = 0; i < `CLWP_QBITS; i++) begin
         fb = c[15] ^ d[i];
         c  = {c[14:0], 1'b0} ^ (fb ? `CLWP_CRC_POLY : 16'h0000);
      end
      return c;
   endfunction

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         grp_q <= '0;
      end else if (ce) begin
         if (do_erase) begin
            grp_q <= '0; // RULE23
         end else if (cmd_wr && grp_ok && op == CLWP_OP_PROTECT) begin
            grp_q[gidx] <= 1'b1; // RULE2
         end else if (cmd_wr && grp_ok && op == CLWP_OP_UNPROTECT) begin
            grp_q[gidx] <= 1'b0; // RULE2
         end
      end
   end

   // query result is captured once and stays until the next query
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qbits_q <= 32'h0000_0000;
         qcrc_q  <= 16'h0000;
      end else if (ce && cmd_wr && grp_ok && op == CLWP_OP_QUERY) begin
         qbits_q <= qsel; // RULE3
         qcrc_q  <= clwp_crc16(qsel); // RULE3
      end
   end

   // ==========
   // lock data block receiver
   logic [7:0] mode_q;
   logic [7:0] len_q;
   logic [5:0] cnt_q;
   logic [7:0] buf_q [`CLWP_BUF_BYTES];
   logic [5:0] boff;

   assign boff = cnt_q - `CLWP_BYTE_PWD;

   // block bytes arrive on rising link edges inside the frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lk_q   <= CLWP_LK_IDLE;
         mode_q <= 8'h00;
         len_q  <= 8'h00;
         cnt_q  <= 6'h00;
      end else if (ce) begin
         case (lk_q)
            CLWP_LK_IDLE: begin
               cnt_q <= 6'h00;
               if (cmd_wr && op == CLWP_OP_LOCK && lk_ok) begin
                  lk_q <= CLWP_LK_ARMED; // RULE8
               end
            end
            CLWP_LK_ARMED: begin
               if (lrise && lfrm_s_q[1] && cnt_q != `CLWP_CNT_MAX) begin
                  cnt_q <= cnt_q + 6'h01; // RULE9
                  if (cnt_q == `CLWP_BYTE_MODE) begin
                     mode_q <= ldat2_q; // RULE10
                  end
                  if (cnt_q == `CLWP_BYTE_LEN) begin
                     len_q <= ldat2_q; // RULE10
                  end
               end
               if (lfall_frm && cnt_q != `CLWP_BYTE_MODE) begin
                  lk_q <= CLWP_LK_EVAL;
               end
            end
            CLWP_LK_EVAL: begin
               lk_q <= CLWP_LK_IDLE;
            end
            default: begin
               lk_q <= CLWP_LK_IDLE;
            end
         endcase
      end
   end

   // password bytes; cleared while idle, so with only a mode byte they read as zero
   always_ff @(posedge pclk) begin
      if (ce && lk_q == CLWP_LK_IDLE) begin
         for (int i = 0; i < `CLWP_BUF_BYTES; i++) begin
            buf_q[i] <= 8'h00;
         end
      end else if (ce && lk_q == CLWP_LK_ARMED && lrise && lfrm_s_q[1]) begin
         if (cnt_q >= `CLWP_BYTE_PWD && boff < 6'(`CLWP_BUF_BYTES)) begin
            buf_q[boff[4:0]] <= ldat2_q; // RULE10 RULE15
         end
      end
   end

   // ==========
   // non-volatile password store
   logic [7:0] pwd_q [`CLWP_PWD_BYTES];
   logic [7:0] plen_q;
   logic [7:0] npwd [`CLWP_PWD_BYTES];
   logic [7:0] nlen;
   logic       ok;
   logic       do_store;
   logic       do_clear;
   logic       do_lock;
   logic       do_unlock;
   logic       prefix_eq;
   logic       match_cur;
   logic       len_valid;
   logic       rsv_zero;
   logic       eval;

   assign eval = ce & (lk_q == CLWP_LK_EVAL);

   // compare and decide; the first of the erase, clear, set, lock bits picks the action, none means unlock
   always_comb begin
      logic [7:0] j;
      j         = 8'h00;
      prefix_eq = 1'b1;
      for (int i = 0; i < `CLWP_PWD_BYTES; i++) begin
         if (8'(i) < plen_q && buf_q[i] != pwd_q[i]) begin
            prefix_eq = 1'b0;
         end
      end
      match_cur = prefix_eq & (len_q == plen_q); // RULE16
      len_valid = (len_q >= `CLWP_PLEN_MIN) & (len_q <= `CLWP_PLEN_MAX); // RULE13
      rsv_zero  = (mode_q[`CLWP_M_RSV_HI:`CLWP_M_RSV_LO] == 4'h0); // RULE25
      nlen      = len_q - plen_q; // RULE15
      for (int i = 0; i < `CLWP_PWD_BYTES; i++) begin
         j = plen_q + 8'(i);
         npwd[i] = (8'(i) < nlen && j < 8'(`CLWP_BUF_BYTES)) ? buf_q[j[4:0]] : 8'h00;
      end
      ok        = 1'b0;
      do_erase  = 1'b0;
      do_store  = 1'b0;
      do_clear  = 1'b0;
      do_lock   = 1'b0;
      do_unlock = 1'b0;
      if (mode_q[`CLWP_M_ERASE]) begin
         ok       = (mode_q == `CLWP_ERASE_ONLY) & locked_q; // RULE11 RULE24
         do_erase = eval & ok; // RULE23
      end else if (mode_q[`CLWP_M_CLR]) begin
         ok       = rsv_zero & len_valid & match_cur; // RULE12 RULE18
         do_clear = eval & ok;
      end else if (mode_q[`CLWP_M_SET]) begin
         ok       = rsv_zero & prefix_eq & (len_q > plen_q) & (nlen >= `CLWP_PLEN_MIN)
                    & (nlen <= `CLWP_PLEN_MAX); // RULE16 RULE13
         do_store = eval & ok;
         do_lock  = eval & ok & mode_q[`CLWP_M_LOCK]; // RULE12
      end else if (mode_q[`CLWP_M_LOCK]) begin
         ok      = rsv_zero & ~locked_q & (plen_q != 8'h00) & len_valid & match_cur; // RULE19 RULE20
         do_lock = eval & ok;
      end else begin
         ok        = rsv_zero & locked_q & len_valid & match_cur; // RULE22
         do_unlock = eval & ok; // RULE21
      end
   end

   // store survives the bus reset; only the blanking reset, a matching clear or a forced erase empties it
   always_ff @(posedge pclk or negedge nvm_blank_n) begin
      if (!nvm_blank_n) begin
         plen_q <= 8'h00;
         for (int i = 0; i < `CLWP_PWD_BYTES; i++) begin
            pwd_q[i] <= 8'h00;
         end
      end else if (ce && (do_clear || do_erase)) begin
         plen_q <= 8'h00; // RULE17 RULE18 RULE23
         for (int i = 0; i < `CLWP_PWD_BYTES; i++) begin
            pwd_q[i] <= 8'h00;
         end
      end else if (ce && do_store) begin
         plen_q <= nlen; // RULE5 RULE16
         for (int i = 0; i < `CLWP_PWD_BYTES; i++) begin
            pwd_q[i] <= npwd[i];
         end
      end
   end

   // ==========
   // lock state and flags
   // first enabled edge after reset decides the lock from the store
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_q   <= 1'b1;
         locked_q <= 1'b0;
      end else if (ce) begin
         if (boot_q) begin
            boot_q   <= 1'b0;
            locked_q <= (plen_q != 8'h00); // RULE7 RULE17
         end else if (do_lock) begin
            locked_q <= 1'b1; // RULE19
         end else if (do_unlock || do_erase) begin
            locked_q <= 1'b0; // RULE21 RULE23
         end
      end
   end

   // sticky flags, cleared by writing one; a new event beats the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fail_q    <= 1'b0;
         illegal_q <= 1'b0;
      end else if (ce) begin
         if (eval && !ok) begin
            fail_q <= 1'b1; // RULE16 RULE18 RULE20 RULE22 RULE24
         end else if (stat_wr && pwdata[`CLWP_ST_FAIL]) begin
            fail_q <= 1'b0;
         end
         if (cmd_wr && ((op == CLWP_OP_LOCK) ? !lk_ok : (op != CLWP_OP_NONE && !grp_ok))) begin
            illegal_q <= 1'b1; // RULE6
         end else if (stat_wr && pwdata[`CLWP_ST_ILLEGAL]) begin
            illegal_q <= 1'b0;
         end
      end
   end

   // ==========
   // status pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         card_locked       <= 1'b0;
         lock_failure_flag <= 1'b0;
      end else if (ce) begin
         card_locked       <= locked_q;
         lock_failure_flag <= fail_q;
      end
   end

endmodule // clwp_card_lock

//--- include/clwp_cfg.svh
// Purpose: address map, field positions and sizes of the card lock block
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   definitions only
`ifndef CLWP_CFG_SVH
`define CLWP_CFG_SVH
// ==========
// register byte offsets
`define CLWP_OFF_CTRL   8'h00
`define CLWP_OFF_CMD    8'h04
`define CLWP_OFF_ARG    8'h08
`define CLWP_OFF_STAT   8'h0C
`define CLWP_OFF_QBITS  8'h10
`define CLWP_OFF_QCRC   8'h14
`define CLWP_OFF_PLEN   8'h18
// ==========
// control and status fields
`define CLWP_CTRL_GEN   0
`define CLWP_CTRL_SEL   1
`define CLWP_CTRL_TWP   2
`define CLWP_CTRL_SZ_LO 8
`define CLWP_CTRL_SZ_HI 11
`define CLWP_ST_LOCKED  0
`define CLWP_ST_FAIL    1
`define CLWP_ST_ILLEGAL 2
`define CLWP_ST_BUSY    3
// ==========
// protection groups
`define CLWP_NGRP       64
`define CLWP_BLK_SHIFT  5'h09
`define CLWP_QBITS      32
`define CLWP_CRC_POLY   16'h1021
`define CLWP_CRC_INIT   16'h0000
// ==========
// lock data block
`define CLWP_PWD_BYTES  16
`define CLWP_BUF_BYTES  32
`define CLWP_BYTE_MODE  6'h00
`define CLWP_BYTE_LEN   6'h01
`define CLWP_BYTE_PWD   6'h02
`define CLWP_CNT_MAX    6'h3F
`define CLWP_M_SET      0
`define CLWP_M_CLR      1
`define CLWP_M_LOCK     2
`define CLWP_M_ERASE    3
`define CLWP_M_RSV_HI   7
`define CLWP_M_RSV_LO   4
`define CLWP_ERASE_ONLY 8'h08
`define CLWP_PLEN_MIN   8'h01
`define CLWP_PLEN_MAX   8'h10
`endif

//--- include/clwp_pkg.sv
// Purpose: types shared by the card lock block
// Assumes: nothing
// Notes:   command codes are written to the command register
package clwp_pkg;
   // ==========
   // command register codes
   typedef enum logic [2:0] {
      CLWP_OP_NONE,
      CLWP_OP_PROTECT,
      CLWP_OP_UNPROTECT,
      CLWP_OP_QUERY,
      CLWP_OP_LOCK
   } clwp_op_type;
   // lock block receiver
   typedef enum logic [1:0] {
      CLWP_LK_IDLE,
      CLWP_LK_ARMED,
      CLWP_LK_EVAL
   } clwp_lk_type;
endpackage

//--- tb/clwp_card_lock_asserts.sv
// Purpose: bus answer and lock output checks of the card lock block
// Assumes: one wait state per access, fail flag sticky until cleared
// Notes:   bound into clwp_card_lock below
`timescale 1ns/1ps
module clwp_card_lock_asserts (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        lnk_frame,
   input wire logic        card_locked,
   input wire logic        lock_failure_flag
);
   // ==========
   // status write that clears the fail flag, held over the whole access
   logic wr_fail;
   assign wr_fail = psel && penable && pwrite && (paddr == 8'h0C) && pwdata[1];
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("no answer one cycle after access");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_ready_cause: assert property (pready |-> $past(psel && penable))
      else $error("ready without access");
   a_slverr_map: assert property (pready |-> (pslverr == (paddr[7:2] > 6'h06)))
      else $error("error answer on wrong address");
   a_stat_lock_bit: assert property (pready && !pwrite && paddr == 8'h0C |-> prdata[0] == card_locked)
      else $error("status lock bit differs from pin");
   a_lock_after_frame: assert property ($changed(card_locked) |-> !lnk_frame && !$past(lnk_frame)
      && !$past(lnk_frame, 2))
      else $error("lock pin moved during a block");
   a_fail_after_frame: assert property ($rose(lock_failure_flag) |-> !lnk_frame && !$past(lnk_frame)
      && !$past(lnk_frame, 2))
      else $error("fail flag rose during a block");
   a_fail_sticky: assert property (lock_failure_flag && !wr_fail && !$past(wr_fail) |=> lock_failure_flag)
      else $error("fail flag dropped without clear");
   a_reset_clean: assert property ($rose(presetn) |-> !card_locked && !lock_failure_flag)
      else $error("outputs not clear at reset release");
endmodule // clwp_card_lock_asserts
bind clwp_card_lock clwp_card_lock_asserts i_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .lnk_frame(lnk_frame), .card_locked(card_locked), .lock_failure_flag(lock_failure_flag));

//--- tb/clwp_host_link.sv
// Purpose: host side of the card link, sends lock data blocks
// Assumes: bytes taken by the card at rising link clock
// Notes:   link clock stands low outside blocks
`timescale 1ns/1ps
module clwp_host_link (
   output logic       lnk_clk,
   output logic       lnk_frame,
   output logic [7:0] lnk_data
);
   // ==========
   // idle bus
   initial begin
      lnk_clk = 1'b0;
      lnk_frame = 1'b0;
      lnk_data = 8'h5A;
   end
   // one block as a single block write: mode, length, password bytes
   task automatic send(input logic [7:0] b [0:19], input int n);
      // non-blocking, since some of these changes fall on a card clock edge
      lnk_frame <= 1'b1;
      for (int i = 0; i < n; i++) begin
         lnk_data <= b[i];
         #62.5 lnk_clk <= 1'b1;
         #62.5 lnk_clk <= 1'b0;
      end
      #62.5 lnk_frame <= 1'b0;
      // released bus must not look like the last byte
      lnk_data <= ~lnk_data;
   endtask
endmodule // clwp_host_link

//--- tb/clwp_card_lock_tb_top.sv
// Purpose: self-checking bench of the card lock block
// Assumes: apb answer waited on, never counted
// Notes:   password bytes are base plus index
`timescale 1ns/1ps
`include "clwp_cfg.svh"
module clwp_card_lock_tb_top
   import clwp_pkg::*;
;
   logic        pclk, presetn, nvm_blank_n, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr, lnk_data;
   logic [31:0] pwdata, prdata, rd;
   logic        lnk_clk, lnk_frame, card_locked, lock_failure_flag;
   logic [7:0]  blk [0:19];
   int          errors, num_checks;
   always #5 pclk = ~pclk;
   clwp_card_lock i_clwp_card_lock (.pclk(pclk), .presetn(presetn), .nvm_blank_n(nvm_blank_n), .ce(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .lnk_clk(lnk_clk), .lnk_frame(lnk_frame), .lnk_data(lnk_data),
      .card_locked(card_locked), .lock_failure_flag(lock_failure_flag));
   clwp_host_link u_host (.lnk_clk(lnk_clk), .lnk_frame(lnk_frame), .lnk_data(lnk_data));
   // ==========
   // helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // outputs are registers, so just after an edge they still show what that edge sampled;
   // the request stands until the edge that sees pready high, data is taken there
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [15:0] crc16(input logic [31:0] v);
      logic [15:0] c;
      c = `CLWP_CRC_INIT;
      for (int i = 0; i < 32; i++) c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? `CLWP_CRC_POLY : 16'h0000);
      return c;
   endfunction
   task automatic qry(input logic [31:0] a, input logic [31:0] exp);
      apb(`CLWP_OFF_ARG, 1'b1, a);
      apb(`CLWP_OFF_CMD, 1'b1, 32'(CLWP_OP_QUERY));
      apb(`CLWP_OFF_QBITS, 1'b0, 32'h0);
      chk(rd, exp);
      apb(`CLWP_OFF_QCRC, 1'b0, 32'h0);
      chk(rd & 32'h0000_FFFF, {16'h0000, crc16(exp)});
   endtask
   // one lock command, then status {fail, locked} and both pins compared
   task automatic op(input logic [7:0] mode, input int ol, input logic [7:0] ob, input int nl,
      input logic [7:0] nb, input logic [1:0] exp);
      int n;
      blk[0] = mode;
      blk[1] = 8'(ol + nl);
      for (int i = 0; i < ol + nl; i++) blk[2 + i] = (i < ol) ? ob + 8'(i) : nb + 8'(i - ol);
      n = mode[3] ? 1 : 2 + ol + nl;
      apb(`CLWP_OFF_CMD, 1'b1, 32'(CLWP_OP_LOCK));
      u_host.send(blk, n);
      n = 0;
      rd = 32'h0000_0008;
      while (rd[3] !== 1'b0 && n < 100) begin
         apb(`CLWP_OFF_STAT, 1'b0, 32'h0);
         n++;
      end
      chk(rd & 32'h0000_0003, {30'h0, exp});
      chk({31'h0, card_locked}, {31'h0, exp[0]});
      chk({31'h0, lock_failure_flag}, {31'h0, exp[1]});
      if (exp[1]) apb(`CLWP_OFF_STAT, 1'b1, 32'h0000_0002);
   endtask
   task automatic rst;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ==========
   // tests take some 21 blocks of at most 2.5 us plus polling, so 500 us is a hang
   initial begin
      #500000;
      errors++;
      report_and_stop;
   end
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      nvm_blank_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (5) @(posedge pclk);
      nvm_blank_n <= 1'b1;
      presetn <= 1'b1;
      apb(`CLWP_OFF_STAT, 1'b0, 32'h0);
      chk(rd, 32'h0);
      apb(8'h40, 1'b0, 32'h0);
      chk({err, rd[30:0]}, 32'h8000_0000);
      // protection groups of two blocks, off then on
      apb(`CLWP_OFF_CTRL, 1'b1, 32'h0000_0102);
      apb(`CLWP_OFF_ARG, 1'b1, 32'h0000_0FFF);
      apb(`CLWP_OFF_CMD, 1'b1, 32'(CLWP_OP_PROTECT));
      apb(`CLWP_OFF_STAT, 1'b0, 32'h0);
      chk(rd & 32'h0000_0004, 32'h0000_0004);
      apb(`CLWP_OFF_STAT, 1'b1, 32'h0000_0004);
      apb(`CLWP_OFF_CTRL, 1'b1, 32'h0000_0103);
      apb(`CLWP_OFF_CMD, 1'b1, 32'(CLWP_OP_PROTECT));
      qry(32'h0000_0400, 32'h0000_0004);
      apb(`CLWP_OFF_ARG, 1'b1, 32'h0000_0C00);
      apb(`CLWP_OFF_CMD, 1'b1, 32'(CLWP_OP_UNPROTECT));
      qry(32'h0000_0400, 32'h0);
      apb(`CLWP_OFF_ARG, 1'b1, 32'h0000_0C00);
      apb(`CLWP_OFF_CMD, 1'b1, 32'(CLWP_OP_PROTECT));
      $display("test groups done");
      op(8'h04, 2, 8'hA0, 0, 8'h00, 2'b10);
      op(8'h01, 0, 8'h00, 2, 8'hA0, 2'b00);
      op(8'h01, 1, 8'hA0, 2, 8'hB0, 2'b10);
      op(8'h04, 2, 8'hB0, 0, 8'h00, 2'b10);
      op(8'h04, 2, 8'hA0, 0, 8'h00, 2'b01);
      op(8'h04, 2, 8'hA0, 0, 8'h00, 2'b11);
      op(8'h00, 2, 8'hA0, 0, 8'h00, 2'b00);
      op(8'h00, 2, 8'hA0, 0, 8'h00, 2'b10);
      op(8'h08, 0, 8'h00, 0, 8'h00, 2'b10);
      $display("test lock done");
      rst;
      apb(`CLWP_OFF_STAT, 1'b0, 32'h0);
      chk(rd & 32'h0000_0001, 32'h0000_0001);
      apb(`CLWP_OFF_CTRL, 1'b1, 32'h0000_0103);
      apb(`CLWP_OFF_CMD, 1'b1, 32'(CLWP_OP_PROTECT));
      apb(`CLWP_OFF_STAT, 1'b0, 32'h0);
      chk(rd & 32'h0000_0004, 32'h0000_0004);
      apb(`CLWP_OFF_STAT, 1'b1, 32'h0000_0004);
      op(8'h09, 0, 8'h00, 0, 8'h00, 2'b11);
      op(8'h08, 0, 8'h00, 0, 8'h00, 2'b00);
      qry(32'h0000_0400, 32'h0);
      op(8'h04, 2, 8'hA0, 0, 8'h00, 2'b10);
      $display("test erase done");
      op(8'h01, 0, 8'h00, 3, 8'hB0, 2'b00);
      op(8'h05, 3, 8'hB0, 2, 8'hA0, 2'b01);
      op(8'h00, 2, 8'hA0, 0, 8'h00, 2'b00);
      op(8'h02, 2, 8'hB0, 0, 8'h00, 2'b10);
      op(8'h06, 2, 8'hA0, 0, 8'h00, 2'b00);
      op(8'h04, 2, 8'hA0, 0, 8'h00, 2'b10);
      op(8'h01, 0, 8'h00, 17, 8'hC0, 2'b10);
      op(8'h01, 0, 8'h00, 16, 8'hC0, 2'b00);
      op(8'h04, 16, 8'hC0, 0, 8'h00, 2'b01);
      apb(`CLWP_OFF_CTRL, 1'b1, 32'h0000_0101);
      apb(`CLWP_OFF_CMD, 1'b1, 32'(CLWP_OP_LOCK));
      apb(`CLWP_OFF_STAT, 1'b0, 32'h0);
      chk(rd & 32'h0000_0004, 32'h0000_0004);
      $display("test password done");
      report_and_stop;
   end
endmodule // clwp_card_lock_tb_top
